/* File: rtl/afsp_regs.vh */
// shared constants for the front-end serial port and interrupt pins
`ifndef AFSP_REGS_VH
`define AFSP_REGS_VH
// =====================================================================
// frame layout
`define AFSP_FRAME_BITS 32
`define AFSP_CNT_W 6
`define AFSP_CMD_BITS 8
`define AFSP_DATA_BITS 24
// command byte: bits 7..1 register index, bit 0 read when set
`define AFSP_CMD_RD_BIT 0
// =====================================================================
// register file
`define AFSP_NUM_REGS 128
`define AFSP_REG_RESET 24'h000000
// =====================================================================
// reference clock
`define AFSP_REF_HZ 32768
`define AFSP_SYS_HZ 250000000
`endif

/* File: rtl/afsp_sync.v */
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ps
`default_nettype none
module afsp_sync
(
    input wire clk_in,
    input wire sys_rst_in,
    input wire async_in,
    input wire rst_val_in,
    output reg sync_out
);
    reg meta_reg;
    // =================================================================
    // synchroniser stages; meta_reg read only by sync_out
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // afsp_sync
`default_nettype wire

/* File: rtl/afsp_serial_port.v */
// serial host port, interrupt pins and reference clock tick of the front end
`timescale 1ns/1ps
`default_nettype none
`include "afsp_regs.vh"
module afsp_serial_port
#(
    parameter FRAME_BITS = `AFSP_FRAME_BITS
)
(
    input wire clk_in,
    input wire sys_rst_in,
    input wire serial_select_n_in,
    input wire serial_clk_in,
    input wire serial_data_in,
    output reg serial_data_out,
    output reg serial_data_oe_out,
    input wire irq_primary_in,
    input wire irq_secondary_in,
    output reg irq_primary_n_out,
    output reg irq_secondary_n_out,
    input wire ref_clock_32k_in,
    output reg ref_tick_out,
    output reg write_strobe_out,
    output reg [6:0] write_addr_out,
    output reg [23:0] write_data_out
);
    // =================================================================
    // synchronised pins
    wire sel_n_s;
    wire sclk_s;
    wire sdi_s;
    wire ref_s;
    wire sel_seed_w;
    wire irq1_s;
    wire irq2_s;
    // select is inverted ahead of its synchroniser, so the cleared
    // reset state reads as deselected and nothing starts before the host acts
    afsp_sync u_sync_sel
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(~serial_select_n_in),
        .rst_val_in(1'b0),
        .sync_out(sel_seed_w)
    );
    assign sel_n_s = ~sel_seed_w;
    // serial clock is only sampled, never used as a clock: no second domain
    afsp_sync u_sync_clk
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(serial_clk_in),
        .rst_val_in(1'b0),
        .sync_out(sclk_s)
    );
    afsp_sync u_sync_sdi
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(serial_data_in),
        .rst_val_in(1'b0),
        .sync_out(sdi_s)
    );
    // reference clock pin, sampled like any other pin
    afsp_sync u_sync_ref
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(ref_clock_32k_in),
        .rst_val_in(1'b0),
        .sync_out(ref_s)
    );
    // status levels may come from other clock domains
    afsp_sync u_sync_irq1
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(irq_primary_in),
        .rst_val_in(1'b0),
        .sync_out(irq1_s)
    );
    afsp_sync u_sync_irq2
    (
        .clk_in(clk_in),
        .sys_rst_in(sys_rst_in),
        .async_in(irq_secondary_in),
        .rst_val_in(1'b0),
        .sync_out(irq2_s)
    );

    // =================================================================
    // state
    reg sclk_d_reg;
    reg ref_d_reg;
    reg [`AFSP_CNT_W-1:0] bit_cnt_reg;
    reg [FRAME_BITS-1:0] shift_in_reg;
    reg [`AFSP_DATA_BITS-1:0] shift_out_reg;
    reg [`AFSP_DATA_BITS-1:0] regs_mem [0:`AFSP_NUM_REGS-1];
    integer i;

    // edge finder shared by the serial clock and the reference clock
    function edge_seen;
        input cur_lvl;
        input prev_lvl;
        begin
            edge_seen = cur_lvl & ~prev_lvl;
        end
    endfunction

    wire sclk_rise = edge_seen(sclk_s, sclk_d_reg);
    wire sclk_fall = edge_seen(sclk_d_reg, sclk_s);
    wire selected = ~sel_n_s;
    wire [FRAME_BITS-1:0] frame_w = {shift_in_reg[FRAME_BITS-2:0], sdi_s};
    // command byte as it stands after the 8th rising edge
    wire [6:0] cmd_addr_w = shift_in_reg[7:1];
    wire cmd_rd_w = shift_in_reg[`AFSP_CMD_RD_BIT];
    wire [`AFSP_DATA_BITS-1:0] rd_word_w = regs_mem[cmd_addr_w];

    // edge detectors read only the second synchroniser stage
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            sclk_d_reg <= 1'b0;
            ref_d_reg <= 1'b0;
        end
        else
        begin
            sclk_d_reg <= sclk_s;
            ref_d_reg <= ref_s;
        end
    end

    // reference tick paces converter and decimator logic downstream
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
            ref_tick_out <= 1'b0;
        else
            ref_tick_out <= edge_seen(ref_s, ref_d_reg);
    end

    // =================================================================
    // input shifting, frame counting, write commit
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            bit_cnt_reg <= {`AFSP_CNT_W{1'b0}};
            shift_in_reg <= {FRAME_BITS{1'b0}};
            write_strobe_out <= 1'b0;
            write_addr_out <= 7'h00;
            write_data_out <= 24'h000000;
        end
        else
        begin
            write_strobe_out <= 1'b0;
            if (!selected)
                bit_cnt_reg <= {`AFSP_CNT_W{1'b0}};
            else if (sclk_rise && bit_cnt_reg < FRAME_BITS)
            begin
                shift_in_reg <= frame_w;
                bit_cnt_reg <= bit_cnt_reg + 6'h01;
                // commit only at the last edge, and only for writes
                if (bit_cnt_reg == FRAME_BITS - 1 && !frame_w[FRAME_BITS-8])
                begin
                    write_strobe_out <= 1'b1;
                    write_addr_out <= frame_w[FRAME_BITS-1:FRAME_BITS-7];
                    write_data_out <= frame_w[`AFSP_DATA_BITS-1:0];
                end
            end
        end
    end

    // register store; an aborted frame never reaches it
    // cleared on reset so that a read of an untouched entry is never unknown
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            for (i = 0; i < `AFSP_NUM_REGS; i = i + 1)
                regs_mem[i] <= `AFSP_REG_RESET;
        end
        else if (write_strobe_out)
            regs_mem[write_addr_out] <= write_data_out;
    end

    // =================================================================
    // output shifting on falling edges; load read data after command
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            shift_out_reg <= 24'h000000;
            serial_data_out <= 1'b0;
            serial_data_oe_out <= 1'b0;
        end
        else
        begin
            serial_data_oe_out <= selected;
            if (!selected)
                serial_data_out <= 1'b0;
            else if (sclk_fall)
            begin
                if (bit_cnt_reg == `AFSP_CMD_BITS && cmd_rd_w)
                begin
                    serial_data_out <= rd_word_w[`AFSP_DATA_BITS-1];
                    shift_out_reg <= {rd_word_w[`AFSP_DATA_BITS-2:0], 1'b0};
                end
                else
                begin
                    serial_data_out <= shift_out_reg[23];
                    shift_out_reg <= {shift_out_reg[22:0], 1'b0};
                end
            end
        end
    end

    // =================================================================
    // interrupt pins, active low, high from reset
    always @(posedge clk_in or posedge sys_rst_in)
    begin
        if (sys_rst_in)
        begin
            irq_primary_n_out <= 1'b1;
            irq_secondary_n_out <= 1'b1;
        end
        else
        begin
            irq_primary_n_out <= ~irq1_s;
            irq_secondary_n_out <= ~irq2_s;
        end
    end
endmodule // afsp_serial_port
`default_nettype wire

/* File: testbench/afsp_serial_port_assertions.sv */
// pin-level checks of the serial port
`timescale 1ns/1ps
`default_nettype none
module afsp_port_checker
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic serial_select_n_in,
    input wire logic serial_clk_in,
    input wire logic serial_data_out,
    input wire logic serial_data_oe_out,
    input wire logic irq_primary_in,
    input wire logic irq_secondary_in,
    input wire logic irq_primary_n_out,
    input wire logic irq_secondary_n_out,
    input wire logic ref_clock_32k_in,
    input wire logic ref_tick_out,
    input wire logic write_strobe_out,
    input wire logic [6:0] write_addr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    // ==========
    // windows allow for the input synchronisers
    oe_release_a: assert property ($rose(serial_select_n_in) |-> ##[1:5] !serial_data_oe_out) else $error("oe held");
    sdo_hold_a: assert property ($rose(serial_clk_in) && !serial_select_n_in |=> $stable(serial_data_out) [*4])
        else $error("sdo moved");
    commit_sel_a: assert property (write_strobe_out |-> !serial_select_n_in) else $error("strobe unselected");
    strobe_pulse_a: assert property (write_strobe_out |=> !write_strobe_out) else $error("strobe long");
    idle_addr_a: assert property (serial_select_n_in [*6] |=> $stable(write_addr_out)) else $error("idle write");
    irq_pri_a: assert property ($changed(irq_primary_in) |-> ##[1:4] (irq_primary_n_out != irq_primary_in))
        else $error("irq1 level");
    irq_sec_a: assert property ($changed(irq_secondary_in) |-> ##[1:4] (irq_secondary_n_out != irq_secondary_in))
        else $error("irq2 level");
    ref_tick_a: assert property ($rose(ref_clock_32k_in) |-> ##[1:5] ref_tick_out) else $error("no tick");
    cover property (write_strobe_out);
    cover property (serial_data_oe_out && serial_data_out);
    cover property (ref_tick_out);
endmodule // afsp_port_checker
bind afsp_serial_port afsp_port_checker chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .serial_select_n_in(serial_select_n_in), .serial_clk_in(serial_clk_in), .serial_data_out(serial_data_out),
    .serial_data_oe_out(serial_data_oe_out), .irq_primary_in(irq_primary_in), .irq_secondary_in(irq_secondary_in),
    .irq_primary_n_out(irq_primary_n_out), .irq_secondary_n_out(irq_secondary_n_out),
    .ref_clock_32k_in(ref_clock_32k_in), .ref_tick_out(ref_tick_out), .write_strobe_out(write_strobe_out),
    .write_addr_out(write_addr_out));
`default_nettype wire

/* File: testbench/afsp_host_model.sv */
// host master of the serial link
`timescale 1ns/1ps
`default_nettype none
module afsp_host_model
(
    input wire logic clk_in,
    input wire logic sdo_in,
    output logic sel_n_out,
    output logic sclk_out,
    output logic sdi_out
);
    // ==========
    // clock stands still outside frames
    initial
    begin
        sel_n_out = 1'b1;
        sclk_out = 1'b0;
        sdi_out = 1'b0;
    end
    // n bits msb first, 68 ns period; reply gathered from bit 8
    task automatic xfer(input logic [31:0] f, input int n, input logic desel, output logic [23:0] rd);
        rd = 24'h0;
        @(posedge clk_in) sel_n_out <= desel;
        for (int i = 0; i < n; i++)
        begin
            @(posedge clk_in) sdi_out <= f[31-i];
            repeat (8) @(posedge clk_in);
            sclk_out <= 1'b1;
            if (i >= 8)
                rd[31-i] = sdo_in;
            repeat (8) @(posedge clk_in);
            sclk_out <= 1'b0;
        end
        repeat (16) @(posedge clk_in);
        sel_n_out <= 1'b1;
        sdi_out <= ~sdi_out; // released line shows no stale bit
        repeat (16) @(posedge clk_in);
    endtask
endmodule // afsp_host_model
`default_nettype wire

/* File: testbench/test_afe_serial_port_and_irq_pins.sv */
// self-checking bench for the serial port and interrupt pins
`timescale 1ns/1ps
`default_nettype none
module test_afe_serial_port_and_irq_pins;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, irq_p = 1'b0, irq_s = 1'b0, ref_clk = 1'b0;
    wire sel_n, sclk, sdi, sdo, oe, irq_p_n, irq_s_n, tick, wstb;
    wire sdo_line;
    int ref_cnt = 0;
    wire [6:0] waddr;
    wire [23:0] wdata;
    logic [23:0] rd;
    int fails = 0, cmp_count = 0, ticks = 0, rises = 0, stbs = 0;
    // ==========
    // clocks; reference kept at its true period
    always #2 clk_in = ~clk_in;
    // 3815 system cycles per half period, stepped on the rising edge
    always @(posedge clk_in)
    begin
        if (ref_cnt == 3814)
        begin
            ref_cnt <= 0;
            ref_clk <= ~ref_clk;
        end
        else
            ref_cnt <= ref_cnt + 1;
    end
    // no pull on the line: a released output shows the inverse to the host
    assign sdo_line = oe ? sdo : ~sdo;
    always @(posedge ref_clk) rises++;
    always @(posedge clk_in) ticks += tick;
    always @(posedge clk_in) stbs += wstb;
    afsp_host_model host (.clk_in(clk_in), .sdo_in(sdo_line), .sel_n_out(sel_n), .sclk_out(sclk), .sdi_out(sdi));
    afsp_serial_port #(.FRAME_BITS(32)) dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .serial_select_n_in(sel_n),
        .serial_clk_in(sclk), .serial_data_in(sdi), .serial_data_out(sdo), .serial_data_oe_out(oe),
        .irq_primary_in(irq_p), .irq_secondary_in(irq_s), .irq_primary_n_out(irq_p_n),
        .irq_secondary_n_out(irq_s_n), .ref_clock_32k_in(ref_clk), .ref_tick_out(tick),
        .write_strobe_out(wstb), .write_addr_out(waddr), .write_data_out(wdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        if (fails == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic t_frames;
        chk({oe, irq_p_n, irq_s_n}, 32'h3);
        host.xfer({7'h55, 1'b0, 24'ha5c3f0}, 32, 1'b0, rd);
        chk(stbs, 1);
        chk({waddr, wdata}, {1'b0, 7'h55, 24'ha5c3f0});
        host.xfer({7'h2a, 1'b0, 24'h123456}, 31, 1'b0, rd);
        host.xfer({7'h11, 1'b0, 24'hffffff}, 32, 1'b1, rd);
        chk({stbs[30:0], oe}, 32'h2);
        host.xfer({7'h55, 1'b1, 24'h0}, 32, 1'b0, rd);
        chk(rd, 24'ha5c3f0);
        host.xfer({7'h2a, 1'b1, 24'h0}, 32, 1'b0, rd);
        chk({rd, stbs[7:0]}, 32'h1);
    endtask
    task automatic t_irq;
        @(posedge clk_in) irq_p <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk({irq_p_n, irq_s_n}, 32'h1);
        irq_p <= 1'b0;
        irq_s <= 1'b1;
        repeat (6) @(posedge clk_in);
        chk({irq_p_n, irq_s_n}, 32'h2);
        irq_s <= 1'b0;
        @(negedge ref_clk);
        repeat (10) @(posedge clk_in);
        chk(ticks, rises);
    endtask
    initial
    begin
        repeat (4) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        t_frames();
        t_irq();
        summarize();
    end
    initial
    begin
        #200000;
        fails++;
        summarize();
    end
endmodule // test_afe_serial_port_and_irq_pins
`default_nettype wire
